// [design/digipot_pkg.sv]
package digipot_pkg;

	// serial frame layout
	localparam int FRAME_BITS = 16;
	localparam int DATA_BITS = 10;
	localparam int SLOT_COUNT = 20;
	localparam int SLOT_ADDR_BITS = 5;
	localparam int SYNC_STAGES = 3;
	localparam logic [4:0] FRAME_BIT_LIMIT = 5'h10;
	localparam logic [3:0] FRAME_MSB_INDEX = 4'hF;
	localparam logic [15:0] FLOAT_PREPARE_WORD = 16'h8001;

	// readback addresses of the fuse memory map
	localparam logic [4:0] ADDR_FUSE_SLOT_FIRST = 5'h00;
	localparam logic [4:0] ADDR_FUSE_SLOT_SECOND = 5'h01;
	localparam logic [4:0] ADDR_FUSE_SLOT_THIRD = 5'h02;
	localparam logic [4:0] ADDR_FUSE_SLOT_FOURTH = 5'h03;
	localparam logic [4:0] ADDR_FUSE_SLOT_FIFTH = 5'h04;
	localparam logic [4:0] ADDR_FUSE_SLOT_TENTH = 5'h09;
	localparam logic [4:0] ADDR_FUSE_SLOT_FIFTEENTH = 5'h0E;
	localparam logic [4:0] ADDR_FUSE_SLOT_TWENTIETH = 5'h13;
	localparam logic [4:0] ADDR_SLOT_USAGE_LOW = 5'h14;
	localparam logic [4:0] ADDR_SLOT_USAGE_HIGH = 5'h15;

	// ones per thermometer usage word
	localparam logic [4:0] USAGE_WORD_ONES = 5'h0A;
	localparam logic [4:0] NO_SLOTS_USED = 5'h00;
	localparam logic [4:0] ONE_SLOT = 5'h01;

	// command codes
	typedef enum logic [3:0] {
		CMD_NOP = 4'h0,
		CMD_WRITE_WIPER = 4'h1,
		CMD_READ_WIPER = 4'h2,
		CMD_STORE_FUSE = 4'h3,
		CMD_SOFT_RESET = 4'h4,
		CMD_READ_FUSE = 4'h5,
		CMD_WRITE_CONTROL = 4'h6,
		CMD_READ_CONTROL = 4'h7,
		CMD_SHUTDOWN = 4'h8
	} command_type;

	// one received frame
	typedef struct packed {
		logic [1:0] spare;
		logic [3:0] command;
		logic [9:0] data;
	} frame_type;

	// control register, bit 0 at the bottom
	typedef struct packed {
		logic fuseProgramOkFlag;
		logic calibrationEnableBit;
		logic wiperWriteUnlockBit;
		logic fuseProgramEnableBit;
	} control_type;

	localparam control_type CONTROL_DEFAULT = 4'h0;
	localparam logic [3:0] CONTROL_WRITABLE = 4'h7;
	localparam int SHUTDOWN_BIT = 0;

endpackage

// [design/digipot_serial_control.sv]
`timescale 1ns/1ps
// Behaviour
// - shutdown command 8 with data bit 0 set enters shutdown
// - shutdown opens terminal A and ties wiper to terminal B
// - entering shutdown keeps the stored wiper code
// - every command still executes while shut down
// - shutdown command 8 with data bit 0 clear leaves shutdown
// - fuse read request names a location; content comes out next frame
// - readback word is 16 bits with content in lowest 10 bits
// - no-operation code 0 clocks out pending data; its only other effect is floating the pin after word 0x8001
// - addresses 0x00 to 0x13 from data bits 4:0 select slots one to twenty
// - addresses 0x14 and 0x15 give thermometer usage words
// - rising hardware reset pin reloads wiper from last programmed slot
// - software reset command 4 does the same reload
// - with no slot programmed any reset loads midscale
// - every reset returns the control register to defaults
// - control default is all four bits zero
// - commands 2, 5, 7 present wiper, fuse slot, control next frame
// - data out changes on rising serial clock edges
// - data out only pulls low or releases
// - word 0x8001 then command 0 floats the data out pin
// - calibration enable bit picks performance or normal resistor mode
// - wiper code decodes to exactly one tap
// - power-up copies the last programmed slot into the wiper
module digipot_serial_control #(
	parameter int WIPER_BITS = 10,
	parameter int TAP_COUNT = 1 << WIPER_BITS
) (
	// system clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// serial link
	input wire logic sclk,
	input wire logic frameSelect_n,
	input wire logic serialIn,
	// open-drain data out pin
	input wire logic serialOutIn,
	output logic serialOut,
	output logic serialOutEn_n,
	// hardware reset pin
	input wire logic hwReset,
	// fuse memory contents and count of programmed slots
	input wire logic [digipot_pkg::SLOT_COUNT-1:0][digipot_pkg::DATA_BITS-1:0] fuseSlots,
	input wire logic [digipot_pkg::SLOT_ADDR_BITS-1:0] fuseUsedCount,
	// resistor network control
	output logic terminalAOpen,
	output logic wiperToB,
	output logic performanceMode,
	output logic [WIPER_BITS-1:0] wiperCode,
	output logic [TAP_COUNT-1:0] tapSelect
);

	localparam logic [WIPER_BITS-1:0] MIDSCALE = {1'b1, {(WIPER_BITS-1){1'b0}}};
	localparam logic [WIPER_BITS-1:0] TAP_ZERO = '0;

	// thermometer word holding the given number of ones from bit 0 up
	function automatic logic [digipot_pkg::DATA_BITS-1:0] thermWord(input logic [4:0] ones);
		logic [digipot_pkg::DATA_BITS-1:0] w;
		w = '0;
		for (int i = 0; i < digipot_pkg::DATA_BITS; i++) begin
			w[i] = (5'(i) < ones);
		end
		return w;
	endfunction

	// a synchroniser output counts once its last two stages agree
	function automatic logic stagesAgree(input logic [digipot_pkg::SYNC_STAGES-1:0] s);
		return s[digipot_pkg::SYNC_STAGES-2] == s[digipot_pkg::SYNC_STAGES-1];
	endfunction

	// zero-extend a readback value into a full response frame
	function automatic logic [digipot_pkg::FRAME_BITS-1:0] padWord(
		input logic [digipot_pkg::DATA_BITS-1:0] v
	);
		return {{(digipot_pkg::FRAME_BITS-digipot_pkg::DATA_BITS){1'b0}}, v};
	endfunction

	// ---------------- link domain (serial clock) ----------------

	logic [digipot_pkg::FRAME_BITS-1:0] shiftIn_r;
	logic [4:0] bitCount_r;
	logic outDrive_r;
	logic nextOutBit;
	logic driveLow;
	logic inResponse;
	logic [3:0] bitIndex;

	// from the system domain, held steady while select is low
	logic [digipot_pkg::FRAME_BITS-1:0] respWord_r;
	logic floatOut_r;

	// input sampled on falling edges, MSB arrives first
	always_ff @(negedge sclk) begin
		shiftIn_r <= {shiftIn_r[digipot_pkg::FRAME_BITS-2:0], serialIn};
	end

	// bit counter, cleared by raised select between frames
	always_ff @(negedge sclk or posedge frameSelect_n) begin
		if (frameSelect_n) begin
			bitCount_r <= '0;
		end else if (bitCount_r != digipot_pkg::FRAME_BIT_LIMIT) begin
			bitCount_r <= bitCount_r + 5'h01;
		end
	end

	// response bit position, counted down from the MSB
	assign inResponse = (bitCount_r < digipot_pkg::FRAME_BIT_LIMIT);
	assign bitIndex = digipot_pkg::FRAME_MSB_INDEX - bitCount_r[3:0];

	// first 16 bits send the response, later bits pass the input on for the chain
	assign nextOutBit = inResponse ? respWord_r[bitIndex] :
		shiftIn_r[digipot_pkg::FRAME_BITS-1];

	// pull low for a zero bit unless the pin is floated
	assign driveLow = ~nextOutBit & ~floatOut_r;

	// output drive updates on rising edges and releases outside frames
	always_ff @(posedge sclk or posedge frameSelect_n) begin
		if (frameSelect_n) begin
			outDrive_r <= 1'b0;
		end else begin
			outDrive_r <= driveLow;
		end
	end

	// open drain: the pin is only ever pulled low
	assign serialOut = 1'b0;
	assign serialOutEn_n = ~outDrive_r;

	// ---------------- system domain ----------------

	logic [digipot_pkg::SYNC_STAGES-1:0] selectSync_r;
	logic [digipot_pkg::SYNC_STAGES-1:0] hwResetSync_r;
	logic selectLevel_r;
	logic hwResetLevel_r;
	logic powerOn_r;
	logic shutdown_r;
	logic floatArm_r;
	logic [WIPER_BITS-1:0] wiper_r;
	logic [TAP_COUNT-1:0] tap_r;
	digipot_pkg::control_type control_r;

	logic frameDone;
	logic hwResetRise;
	logic reload;
	digipot_pkg::frame_type frameWord;
	logic [3:0] command;
	logic [digipot_pkg::SLOT_ADDR_BITS-1:0] fuseAddr;
	logic [WIPER_BITS-1:0] lastSlot;
	logic [4:0] lowOnes;
	logic [4:0] highOnes;
	logic [digipot_pkg::DATA_BITS-1:0] fuseWord;
	logic [digipot_pkg::FRAME_BITS-1:0] respNxt;
	logic [WIPER_BITS-1:0] wiperNxt;
	digipot_pkg::control_type controlNxt;
	logic shutdownNxt;
	logic floatArmNxt;
	logic floatOutNxt;
	logic [TAP_COUNT-1:0] tapNxt;
	logic selectSettled;
	logic hwResetSettled;
	logic selectNow;
	logic hwResetNow;
	logic softResetCmd;
	logic [digipot_pkg::FRAME_BITS-1:0] respWiper;
	logic [digipot_pkg::FRAME_BITS-1:0] respFuse;
	logic [digipot_pkg::FRAME_BITS-1:0] respControl;
	digipot_pkg::control_type controlWritten;

	// three-stage synchroniser for the select pin
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			selectSync_r <= '1;
		end else begin
			selectSync_r <= {selectSync_r[digipot_pkg::SYNC_STAGES-2:0], frameSelect_n};
		end
	end

	// three-stage synchroniser for the hardware reset pin
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			hwResetSync_r <= '1;
		end else begin
			hwResetSync_r <= {hwResetSync_r[digipot_pkg::SYNC_STAGES-2:0], hwReset};
		end
	end

	// settled synchroniser outputs: last two stages agree
	assign selectSettled = stagesAgree(selectSync_r);
	assign hwResetSettled = stagesAgree(hwResetSync_r);
	assign selectNow = selectSync_r[digipot_pkg::SYNC_STAGES-1];
	assign hwResetNow = hwResetSync_r[digipot_pkg::SYNC_STAGES-1];

	// filtered select level, only follows a settled value
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			selectLevel_r <= 1'b1;
		end else if (selectSettled) begin
			selectLevel_r <= selectNow;
		end
	end

	// filtered reset pin level, same filtering as select
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			hwResetLevel_r <= 1'b1;
		end else if (hwResetSettled) begin
			hwResetLevel_r <= hwResetNow;
		end
	end

	// frame end and hardware reset edge events
	assign frameDone = selectSettled & selectNow & ~selectLevel_r;
	assign hwResetRise = hwResetSettled & hwResetNow & ~hwResetLevel_r;

	// power-on preset fires in the first cycle after reset release
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			powerOn_r <= 1'b1;
		end else begin
			powerOn_r <= 1'b0;
		end
	end

	// the shift register is idle once select has settled high
	assign frameWord = digipot_pkg::frame_type'(shiftIn_r);
	assign command = frameWord.command;
	assign fuseAddr = frameWord.data[digipot_pkg::SLOT_ADDR_BITS-1:0];

	// any reset source reloads the wiper and control register
	assign softResetCmd = frameDone & (command == digipot_pkg::CMD_SOFT_RESET);
	assign reload = powerOn_r | hwResetRise | softResetCmd;

	// most recent slot, or midscale when nothing was programmed
	assign lastSlot = (fuseUsedCount == digipot_pkg::NO_SLOTS_USED) ? MIDSCALE :
		fuseSlots[fuseUsedCount - digipot_pkg::ONE_SLOT][WIPER_BITS-1:0];

	// usage words: total ones equal the number of programmed slots
	assign lowOnes = (fuseUsedCount > digipot_pkg::USAGE_WORD_ONES) ?
		digipot_pkg::USAGE_WORD_ONES : fuseUsedCount;
	assign highOnes = (fuseUsedCount > digipot_pkg::USAGE_WORD_ONES) ?
		fuseUsedCount - digipot_pkg::USAGE_WORD_ONES : digipot_pkg::NO_SLOTS_USED;

	// fuse memory map read
	assign fuseWord = (fuseAddr <= digipot_pkg::ADDR_FUSE_SLOT_TWENTIETH) ? fuseSlots[fuseAddr] :
		(fuseAddr == digipot_pkg::ADDR_SLOT_USAGE_LOW) ? thermWord(lowOnes) :
		(fuseAddr == digipot_pkg::ADDR_SLOT_USAGE_HIGH) ? thermWord(highOnes) :
		'0;

	// readback words, content in the low bits
	assign respWiper = padWord(digipot_pkg::DATA_BITS'(wiper_r));
	assign respFuse = padWord(fuseWord);
	assign respControl = padWord(digipot_pkg::DATA_BITS'(control_r));

	// writable control bits come from the low data bits of the frame
	assign controlWritten = (control_r & ~digipot_pkg::CONTROL_WRITABLE) |
		(frameWord.data[$bits(digipot_pkg::control_type)-1:0] & digipot_pkg::CONTROL_WRITABLE);

	// command decode; runs the same whether or not shut down
	// a readback command cancels a floated data out so its answer can be seen
	always_comb begin
		respNxt = respWord_r;
		wiperNxt = wiper_r;
		controlNxt = control_r;
		shutdownNxt = shutdown_r;
		floatArmNxt = floatArm_r;
		floatOutNxt = floatOut_r;
		if (frameDone) begin
			respNxt = shiftIn_r;
			floatArmNxt = (shiftIn_r == digipot_pkg::FLOAT_PREPARE_WORD);
			unique case (command)
				digipot_pkg::CMD_NOP: begin
					floatOutNxt = floatOut_r | floatArm_r;
				end
				digipot_pkg::CMD_WRITE_WIPER: begin
					if (control_r.wiperWriteUnlockBit) begin
						wiperNxt = frameWord.data[WIPER_BITS-1:0];
					end
				end
				digipot_pkg::CMD_READ_WIPER: begin
					respNxt = respWiper;
					floatOutNxt = 1'b0;
				end
				digipot_pkg::CMD_READ_FUSE: begin
					respNxt = respFuse;
					floatOutNxt = 1'b0;
				end
				digipot_pkg::CMD_WRITE_CONTROL: begin
					controlNxt = controlWritten;
				end
				digipot_pkg::CMD_READ_CONTROL: begin
					respNxt = respControl;
					floatOutNxt = 1'b0;
				end
				digipot_pkg::CMD_SHUTDOWN: begin
					shutdownNxt = frameWord.data[digipot_pkg::SHUTDOWN_BIT];
				end
				default: begin
					respNxt = shiftIn_r;
				end
			endcase
		end
		if (reload) begin
			wiperNxt = lastSlot;
			controlNxt = digipot_pkg::CONTROL_DEFAULT;
		end
	end

	// wiper and control registers
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			wiper_r <= MIDSCALE;
			control_r <= digipot_pkg::CONTROL_DEFAULT;
		end else begin
			wiper_r <= wiperNxt;
			control_r <= controlNxt;
		end
	end

	// shutdown state; resets from the pin or command leave it alone
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			shutdown_r <= 1'b0;
		end else begin
			shutdown_r <= shutdownNxt;
		end
	end

	// response word and float control, read by the link side while select is low
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			respWord_r <= '0;
			floatArm_r <= 1'b0;
			floatOut_r <= 1'b0;
		end else begin
			respWord_r <= respNxt;
			floatArm_r <= floatArmNxt;
			floatOut_r <= floatOutNxt;
		end
	end

	// one tap per code; shutdown parks the wiper at the B end
	for (genvar i = 0; i < TAP_COUNT; i++) begin : gen_tap
		assign tapNxt[i] = shutdown_r ? (WIPER_BITS'(i) == TAP_ZERO) :
			(wiper_r == WIPER_BITS'(i));
	end

	// registered tap select
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			tap_r <= '0;
		end else begin
			tap_r <= tapNxt;
		end
	end

	// resistor network outputs
	assign terminalAOpen = shutdown_r;
	assign wiperToB = shutdown_r;
	assign performanceMode = ~control_r.calibrationEnableBit;
	assign wiperCode = wiper_r;
	assign tapSelect = tap_r;

endmodule

// [tb/digipot_host_model.sv]
`timescale 1ns/1ps
module digipot_host_model (
	// link toward the device
	output logic sclk,
	output logic frameSelect_n,
	output logic serialIn,
	// resolved data out pin
	input wire logic pin
);
	// link clock rests low between frames
	initial begin
		sclk = 1'b0;
		frameSelect_n = 1'b1;
		serialIn = 1'b0;
	end
	// data moves well away from the falling edge the device samples on
	task automatic shift_bit(input logic d, output logic q);
		#5 serialIn = d;
		#10 sclk = 1'b1;
		#14 q = pin;
		#1 sclk = 1'b0;
	endtask
	// one frame, msb first, gap of ten mclk after select rises
	task automatic frame(input logic [15:0] w, output logic [15:0] r);
		frameSelect_n = 1'b0;
		for (int i = 15; i >= 0; i--) shift_bit(w[i], r[i]);
		#15 frameSelect_n = 1'b1;
		#400 serialIn = ~serialIn;
	endtask
	// two chained frames under one select, far device first
	task automatic chain(input logic [31:0] w, output logic [31:0] r);
		frameSelect_n = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			shift_bit(w[i], r[i]);
			#30;
		end
		#15 frameSelect_n = 1'b1;
		#400 serialIn = ~serialIn;
	endtask
endmodule

// [tb/digipot_serial_control_bench.sv]
`timescale 1ns/1ps
module digipot_serial_control_bench;
	logic mclk, reset_n, hwReset, sclk, frameSelect_n, serialIn, serialOut, serialOutEn_n;
	logic terminalAOpen, wiperToB, performanceMode;
	logic [19:0][9:0] slots;
	logic [4:0] fuseUsedCount;
	logic [9:0] wiperCode;
	logic [1023:0] tapSelect;
	logic [15:0] rx;
	logic [31:0] r32;
	int bad_count = 0;
	int checks = 0;
	// open-drain pin with pull-up
	wire pin = serialOutEn_n ? 1'b1 : serialOut;
	digipot_serial_control DUT (.mclk(mclk), .reset_n(reset_n), .sclk(sclk),
		.frameSelect_n(frameSelect_n), .serialIn(serialIn), .serialOutIn(pin),
		.serialOut(serialOut), .serialOutEn_n(serialOutEn_n), .hwReset(hwReset),
		.fuseSlots(slots), .fuseUsedCount(fuseUsedCount), .terminalAOpen(terminalAOpen),
		.wiperToB(wiperToB), .performanceMode(performanceMode), .wiperCode(wiperCode),
		.tapSelect(tapSelect));
	digipot_host_model host (.sclk(sclk), .frameSelect_n(frameSelect_n),
		.serialIn(serialIn), .pin(pin));
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// hardware reset pin pulse, long enough for the synchroniser
	task automatic pulse;
		@(negedge mclk) hwReset = 1'b1;
		repeat (8) @(negedge mclk);
		hwReset = 1'b0;
		repeat (8) @(negedge mclk);
	endtask
	task automatic t_preset;
		check(wiperCode, slots[16], "preset");
		check(performanceMode, 1'b1, "mode");
		host.frame(16'h1C00, rx);
		host.frame(16'h0000, rx);
		check(rx, 16'h0000, "control");
	endtask
	task automatic t_fuse;
		host.frame(16'h1414, rx);
		host.frame(16'h1415, rx);
		check(rx, 16'h03FF, "usage low");
		host.frame(16'h17F0, rx);
		check(rx, 16'h007F, "usage high");
		host.frame(16'h17E0, rx);
		check(rx, {6'h00, slots[16]}, "slot 16");
		host.frame(16'h1413, rx);
		check(rx, {6'h00, slots[0]}, "slot 0");
		host.frame(16'h0000, rx);
		check(rx, {6'h00, slots[19]}, "slot 19");
	endtask
	task automatic t_shutdown;
		host.frame(16'h1802, rx);
		host.frame(16'h0555, rx);
		check(wiperCode, 10'h155, "write");
		host.frame(16'h2001, rx);
		check({terminalAOpen, wiperToB, wiperCode}, {2'b11, 10'h155}, "enter");
		host.frame(16'h0800, rx);
		host.frame(16'h0000, rx);
		check(rx, 16'h0155, "wiper read");
		host.frame(16'h1000, rx);
		check({terminalAOpen, wiperCode}, {1'b1, slots[16]}, "soft reset");
		host.frame(16'h2000, rx);
		check(terminalAOpen, 1'b0, "exit");
	endtask
	task automatic t_hwreset;
		host.frame(16'h1807, rx);
		check(performanceMode, 1'b0, "normal mode");
		host.frame(16'h0432, rx);
		@(negedge mclk) fuseUsedCount = 5'h00;
		pulse();
		check(wiperCode, 10'h200, "midscale");
		@(negedge mclk) fuseUsedCount = 5'h11;
		pulse();
		check(wiperCode, slots[16], "hw reload");
		host.frame(16'h1C00, rx);
		host.frame(16'h0000, rx);
		check({rx, performanceMode}, {16'h0000, 1'b1}, "control cleared");
	endtask
	task automatic t_float;
		host.frame(16'h8001, rx);
		host.frame(16'h0000, rx);
		host.frame(16'h0000, rx);
		check(rx, 16'hFFFF, "floated");
		host.frame(16'h1C00, rx);
		check(rx, 16'hFFFF, "still floated");
	endtask
	task automatic t_chain;
		host.chain({16'h2001, 16'h1C00}, r32);
		check({terminalAOpen, r32[15:0]}, {1'b0, 16'h2001}, "chain");
	endtask
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// 23 frames of under 1 us each plus one 2.3 us chained pair; 100 us is ample
	initial begin
		#100000;
		bad_count++;
		results();
	end
	initial begin
		reset_n = 1'b0;
		hwReset = 1'b0;
		fuseUsedCount = 5'h11;
		for (int i = 0; i < 20; i++) slots[i] = 10'(i * 10'h025 + 10'h064);
		repeat (3) @(negedge mclk);
		reset_n = 1'b1;
		repeat (4) @(negedge mclk);
		t_preset();
		t_fuse();
		t_shutdown();
		t_hwreset();
		t_float();
		t_chain();
		results();
	end
endmodule

// [tb/digipot_serial_control_props.sv]
`timescale 1ns/1ps
module digipot_serial_control_props #(
	parameter int WIPER_BITS = 10,
	parameter int TAP_COUNT = 1 << WIPER_BITS
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// pins
	input wire logic frameSelect_n,
	input wire logic serialOut,
	input wire logic serialOutEn_n,
	input wire logic hwReset,
	input wire logic [digipot_pkg::SLOT_COUNT-1:0][digipot_pkg::DATA_BITS-1:0] fuseSlots,
	input wire logic [digipot_pkg::SLOT_ADDR_BITS-1:0] fuseUsedCount,
	// resistor network
	input wire logic terminalAOpen,
	input wire logic wiperToB,
	input wire logic performanceMode,
	input wire logic [WIPER_BITS-1:0] wiperCode,
	input wire logic [TAP_COUNT-1:0] tapSelect
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// code any reload must give
	logic [WIPER_BITS-1:0] reloadCode;
	assign reloadCode = (fuseUsedCount == 5'h00) ? WIPER_BITS'(1) << (WIPER_BITS - 1)
		: WIPER_BITS'(fuseSlots[fuseUsedCount - 5'h01]);
	// a frame was just executed after select went high
	sequence s_exec;
		frameSelect_n && $past(frameSelect_n, 2);
	endsequence
	sequence s_reload;
		##[1:6] wiperCode == reloadCode;
	endsequence
	property p_ends; terminalAOpen |-> wiperToB; endproperty
	property p_shut_tap; terminalAOpen && $past(terminalAOpen) |-> tapSelect == TAP_COUNT'(1);
	endproperty
	property p_keep; $rose(terminalAOpen) |-> $stable(wiperCode); endproperty
	property p_enter; $rose(terminalAOpen) |-> s_exec; endproperty
	property p_tap; $past(reset_n) && !terminalAOpen && !$past(terminalAOpen)
		&& $stable(wiperCode) |-> tapSelect == (TAP_COUNT'(1) << wiperCode); endproperty
	property p_perf; $fell(performanceMode) |-> s_exec; endproperty
	property p_drain; serialOut == 1'b0 && (frameSelect_n -> serialOutEn_n); endproperty
	property p_hw; $rose(hwReset) |-> s_reload; endproperty
	property p_preset; $rose(reset_n) |-> ##[0:2] wiperCode == reloadCode; endproperty
	a_ends: assert property (p_ends) else $error("wiper not at B in shutdown");
	a_shut_tap: assert property (p_shut_tap) else $error("tap not at B end");
	a_keep: assert property (p_keep) else $error("wiper changed on shutdown");
	a_enter: assert property (p_enter) else $error("shutdown without frame");
	a_tap: assert property (p_tap) else $error("tap not one-hot of wiper");
	a_perf: assert property (p_perf) else $error("mode left without frame");
	a_drain: assert property (p_drain) else $error("data out driven high");
	a_hw: assert property (p_hw) else $error("hardware reset reload wrong");
	a_preset: assert property (p_preset) else $error("power-on preset wrong");
endmodule
bind digipot_serial_control digipot_serial_control_props #(.WIPER_BITS(WIPER_BITS),
	.TAP_COUNT(TAP_COUNT)) props (.mclk(mclk), .reset_n(reset_n),
	.frameSelect_n(frameSelect_n), .serialOut(serialOut), .serialOutEn_n(serialOutEn_n),
	.hwReset(hwReset), .fuseSlots(fuseSlots), .fuseUsedCount(fuseUsedCount),
	.terminalAOpen(terminalAOpen), .wiperToB(wiperToB), .performanceMode(performanceMode),
	.wiperCode(wiperCode), .tapSelect(tapSelect));
